// ---- verilog/fpu_hold_map.svh ----
`ifndef FPU_HOLD_MAP_SVH
`define FPU_HOLD_MAP_SVH
// =====================================================
// widths and timing
`define ADDR_W 32
`define DATA_W 32
`define RESET_MIN_CYCLES 8
`define CLK_PERIOD_NS 5
`define RST_CNT_W 4
// =====================================================
// reset values
`define ADDR_RST 32'h0000_0000
`define FSR_RST 32'h0000_0000
// writable fsr fields; version and reserved bits stay read-only
`define FSR_WR_MASK 32'hCFC0_0FFF
`define FSR_VER_LSB 17
`define FSR_VER_MSB 19
// =====================================================
// store sizes
`define ST_WORD 1'b0
`define ST_DOUBLE 1'b1
`endif

// ---- verilog/fpu_hold_pkg.sv ----
package fpu_hold_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA1,
        ST_DATA2,
        ST_DATA3
    } store_state_t;
endpackage

// ---- verilog/transparent_latch.sv ----
`timescale 1ns/1ps
// =====================================================
// level-sensitive latch, open while clk is low
// closed across the rising edge, so sampling registers never race an open latch
module transparent_latch (
    input wire logic clk_sys_i,
    input wire logic d_i,
    output logic q_o
);
    always_latch
    begin
        if (!clk_sys_i)
        begin
            q_o <= d_i;
        end
    end
endmodule

// ---- verilog/fpu_hold_and_bus_interface.sv ----
`timescale 1ns/1ps
`include "fpu_hold_map.svh"
// Overview of operation
// - auxiliary hold passes through a transparent latch before use.
// - device waits while latched auxiliary condition-valid is low.
// - capture instruction address into decode reg; copy to buffer-one on fetch.
// - drive data bus only during stores; data presented unlatched.
// - store data valid in data cycle two, or two and three for doubles.
// - doublewords align to 8 bytes, words to 4 bytes.
// - data output enable deasserted puts data drivers off.
// - either memory hold freezes the pipeline.
// - bus hold freezes the pipeline.
// - memory data strobe loads data while pipeline clock stopped.
// - nullify output asserted while own hold or own condition wait active.
// - reset clears pipeline and writable status fields to zero.
// - every stage starts on the rising clock edge.
// - own hold asserted cycle after decode dependency found.
module fpu_hold_and_bus_interface (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic aux_cop_hold_n_i,
    input wire logic aux_cond_valid_i,
    input wire logic [1:0] aux_cond_bits_i,
    input wire logic mem_hold_a_n_i,
    input wire logic mem_hold_b_n_i,
    input wire logic bus_hold_n_i,
    input wire logic mem_data_strobe_n_i,
    input wire logic data_out_en_n_i,
    input wire logic iu_nullify_i,
    input wire logic fetch_strobe_i,
    input wire logic fp_instr_i,
    input wire logic decode_dep_i,
    input wire logic fp_cond_valid_i,
    input wire logic store_start_i,
    input wire logic store_double_i,
    input wire logic [63:0] store_word_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [`DATA_W-1:0] data_i,
    input wire logic fsr_wr_i,
    output logic [`ADDR_W-1:0] decode_addr_o,
    output logic [`ADDR_W-1:0] buf1_addr_o,
    output logic [`DATA_W-1:0] data_o,
    output logic [`DATA_W/8-1:0] data_oe_o,
    output logic fp_own_hold_n_o,
    output logic freeze_o,
    output logic nullify_cycle_o,
    output logic align_err_o,
    output logic [`DATA_W-1:0] load_data_o,
    output logic [1:0] aux_cond_bits_o,
    output logic [31:0] fsr_o
);
    // =====================================================
    // latched coprocessor inputs
    // latches hold still across the rising edge, so stage registers see a settled copy
    logic aux_hold_lat;
    logic aux_cv_lat;
    transparent_latch u_hold_lat (
        .clk_sys_i(clk_sys_i),
        .d_i(aux_cop_hold_n_i),
        .q_o(aux_hold_lat)
    );
    transparent_latch u_cv_lat (
        .clk_sys_i(clk_sys_i),
        .d_i(aux_cond_valid_i),
        .q_o(aux_cv_lat)
    );
    // =====================================================
    // hold merging
    logic own_hold_n_reg, own_hold_n_next;
    logic freeze_reg, freeze_next;
    logic null_reg, null_next;
    logic cond_wait;
    logic ext_hold;
    always_comb
    begin
        cond_wait = !aux_cv_lat;
        ext_hold = !mem_hold_a_n_i || !mem_hold_b_n_i || !bus_hold_n_i;
        // own hold one cycle after decode dependency
        own_hold_n_next = !(decode_dep_i && fp_instr_i);
        // single freeze; coprocessor hold same cycle
        freeze_next = !own_hold_n_next || !aux_hold_lat || cond_wait || ext_hold
                      || !fp_cond_valid_i;
        // nullify on own hold or own condition wait; coprocessor waits are not ours
        null_next = !own_hold_n_next || !fp_cond_valid_i;
    end
    // =====================================================
    // addresses, fsr, load path
    logic [`ADDR_W-1:0] dda_reg, dda_next;
    logic [`ADDR_W-1:0] da1_reg, da1_next;
    logic [31:0] fsr_reg, fsr_next;
    logic [`DATA_W-1:0] load_reg, load_next;
    logic [1:0] ccb_reg, ccb_next;
    logic strobe_prev_reg, strobe_prev_next;
    logic strobe_fall;
    always_comb
    begin
        dda_next = dda_reg;
        da1_next = da1_reg;
        fsr_next = fsr_reg;
        load_next = load_reg;
        ccb_next = ccb_reg;
        strobe_fall = strobe_prev_reg && !mem_data_strobe_n_i;
        // prev follows the pin through reset, so no false edge after it
        strobe_prev_next = mem_data_strobe_n_i;
        if (!freeze_next && fp_instr_i)
        begin
            dda_next = addr_i;
        end
        if (fetch_strobe_i)
        begin
            da1_next = dda_reg;
        end
        // strobe loads data even when frozen
        if (freeze_next && strobe_fall)
        begin
            load_next = data_i;
        end
        else if (!freeze_next)
        begin
            load_next = data_i;
        end
        if (aux_cv_lat)
        begin
            ccb_next = aux_cond_bits_i;
        end
        if (fsr_wr_i && !freeze_next)
        begin
            fsr_next = (data_i & `FSR_WR_MASK) | (fsr_reg & ~`FSR_WR_MASK);
        end
    end
    // =====================================================
    // store sequencing
    fpu_hold_pkg::store_state_t st_reg, st_next;
    logic dbl_reg, dbl_next;
    logic [63:0] sdata_reg, sdata_next;
    logic [`DATA_W-1:0] dout_reg, dout_next;
    logic drive_reg, drive_next;
    logic aerr_reg, aerr_next;
    always_comb
    begin
        st_next = st_reg;
        dbl_next = dbl_reg;
        sdata_next = sdata_reg;
        aerr_next = 1'b0;
        if (!freeze_next)
        begin
            case (st_reg)
                fpu_hold_pkg::ST_IDLE:
                begin
                    if (store_start_i && !iu_nullify_i)
                    begin
                        aerr_next = store_double_i ? (addr_i[2:0] != 3'h0)
                                                   : (addr_i[1:0] != 2'h0);
                        if (!aerr_next)
                        begin
                            st_next = fpu_hold_pkg::ST_DATA1;
                            dbl_next = store_double_i;
                            sdata_next = store_word_i;
                        end
                    end
                end
                fpu_hold_pkg::ST_DATA1: st_next = fpu_hold_pkg::ST_DATA2;
                fpu_hold_pkg::ST_DATA2:
                    st_next = dbl_reg ? fpu_hold_pkg::ST_DATA3 : fpu_hold_pkg::ST_IDLE;
                fpu_hold_pkg::ST_DATA3: st_next = fpu_hold_pkg::ST_IDLE;
                default: st_next = fpu_hold_pkg::ST_IDLE;
            endcase
        end
        // drive only during store, presented one cycle early
        // valid in data cycle two (and three for doubles)
        drive_next = (st_next == fpu_hold_pkg::ST_DATA2)
                     || (st_next == fpu_hold_pkg::ST_DATA3);
        dout_next = (st_next == fpu_hold_pkg::ST_DATA3) ? sdata_next[31:0]
                                                        : sdata_next[63:32];
        if (!data_out_en_n_i == 1'b0)
        begin
            drive_next = 1'b0;
        end
    end
    // =====================================================
    // registers, rising edge only
    // all stages on rising edge
    always_ff @(posedge clk_sys_i)
    begin
        strobe_prev_reg <= strobe_prev_next;
        // reset clears pipeline and writable fsr fields
        if (rst_i)
        begin
            own_hold_n_reg <= 1'b1;
            freeze_reg <= 1'b0;
            null_reg <= 1'b0;
            dda_reg <= `ADDR_RST;
            da1_reg <= `ADDR_RST;
            fsr_reg <= `FSR_RST;
            load_reg <= '0;
            ccb_reg <= 2'h0;
            st_reg <= fpu_hold_pkg::ST_IDLE;
            dbl_reg <= 1'b0;
            sdata_reg <= '0;
            dout_reg <= '0;
            drive_reg <= 1'b0;
            aerr_reg <= 1'b0;
        end
        else
        begin
            own_hold_n_reg <= own_hold_n_next;
            freeze_reg <= freeze_next;
            null_reg <= null_next;
            dda_reg <= dda_next;
            da1_reg <= da1_next;
            fsr_reg <= fsr_next;
            load_reg <= load_next;
            ccb_reg <= ccb_next;
            st_reg <= st_next;
            dbl_reg <= dbl_next;
            sdata_reg <= sdata_next;
            dout_reg <= dout_next;
            drive_reg <= drive_next;
            aerr_reg <= aerr_next;
        end
    end
    always_comb
    begin
        decode_addr_o = dda_reg;
        buf1_addr_o = da1_reg;
        data_o = dout_reg;
        data_oe_o = {(`DATA_W/8){drive_reg}};
        fp_own_hold_n_o = own_hold_n_reg;
        freeze_o = freeze_reg;
        nullify_cycle_o = null_reg;
        align_err_o = aerr_reg;
        load_data_o = load_reg;
        aux_cond_bits_o = ccb_reg;
        fsr_o = fsr_reg;
    end
    // =====================================================
    // checks
    chk_mem_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !mem_hold_a_n_i || !mem_hold_b_n_i |=> freeze_o)
        else $error("memory hold did not freeze");
    chk_bus_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !bus_hold_n_i |=> freeze_o)
        else $error("bus hold did not freeze");
    chk_cond_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !aux_cond_valid_i |=> freeze_o)
        else $error("missing condition wait");
    chk_own_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (decode_dep_i && fp_instr_i) |=> !fp_own_hold_n_o && nullify_cycle_o)
        else $error("own hold late");
    chk_addr_copy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fetch_strobe_i |=> buf1_addr_o == $past(decode_addr_o))
        else $error("buffer address not copied");
    chk_oe_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        data_out_en_n_i |=> data_oe_o == '0)
        else $error("drivers on while disabled");
    chk_no_idle_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == fpu_hold_pkg::ST_IDLE |-> !drive_reg)
        else $error("driving outside store");
    chk_reset_fsr: assert property (@(posedge clk_sys_i)
        rst_i |=> (fsr_o & `FSR_WR_MASK) == 32'h0000_0000)
        else $error("fsr not cleared");
    chk_word_align: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (st_reg == fpu_hold_pkg::ST_IDLE && !freeze_next && store_start_i && !iu_nullify_i
         && !store_double_i && addr_i[1:0] != 2'h0) |=> align_err_o)
        else $error("misaligned word accepted");
    chk_cop_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !aux_cop_hold_n_i |=> freeze_o)
        else $error("coprocessor hold did not freeze");
    chk_null_cond: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !fp_cond_valid_i |=> nullify_cycle_o && freeze_o)
        else $error("condition wait not nullified");
    chk_strobe_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        freeze_next && strobe_fall |=> load_data_o == $past(data_i))
        else $error("strobe did not load data");
    chk_double_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == fpu_hold_pkg::ST_DATA2 && dbl_reg && !freeze_next |=> st_reg == fpu_hold_pkg::ST_DATA3)
        else $error("double store lost its third cycle");
    cov_store_double: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == fpu_hold_pkg::ST_DATA3);
    cov_strobe_load: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        freeze_next && strobe_fall);
    cov_fetch: cover property (@(posedge clk_sys_i) disable iff (rst_i) fetch_strobe_i);
    // =====================================================
    // store outcomes
    cov_store_word: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == fpu_hold_pkg::ST_DATA2 && !dbl_reg);
    cov_align_err: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        align_err_o);
endmodule

// ---- tb/aux_mem_model.sv ----
`timescale 1ns/1ps
// ==========
// coprocessor and memory side, changes on the falling edge
module aux_mem_model (
    input wire logic clk_sys_i,
    input wire logic en_i,
    input wire logic oe_off_i,
    input wire logic [7:0] rnd_i,
    output logic aux_cop_hold_n_o,
    output logic aux_cond_valid_o,
    output logic [1:0] aux_cond_bits_o,
    output logic mem_hold_a_n_o,
    output logic mem_hold_b_n_o,
    output logic bus_hold_n_o,
    output logic mem_data_strobe_n_o,
    output logic data_out_en_n_o
);
    logic [8:0] drv = 9'h0F3;
    logic [1:0] pend = 2'h0;
    logic hold;
    assign hold = !(drv[4] && drv[5] && drv[6]);
    assign {mem_data_strobe_n_o, bus_hold_n_o, mem_hold_b_n_o, mem_hold_a_n_o} = drv[7:4];
    assign {aux_cond_bits_o, aux_cond_valid_o, aux_cop_hold_n_o} = drv[3:0];
    // enable off only in the cycle after a memory or bus hold, or while oe_off_i is set
    assign data_out_en_n_o = drv[8] | oe_off_i;
    always @(negedge clk_sys_i)
    begin
        if (en_i)
        begin
            // hold raised on a dependency, dropped again soon
            drv[0] <= !(rnd_i[0] && rnd_i[1]);
            // valid low while a compare is pending
            pend <= (pend != 2'h0) ? pend - 2'h1 : {rnd_i[2], rnd_i[2]};
            drv[1] <= (pend == 2'h0) && !rnd_i[2];
            // bits are junk while not valid, never a stale copy
            drv[3:2] <= ((pend == 2'h0) && !rnd_i[2]) ? rnd_i[4:3] : ~drv[3:2];
            drv[4] <= !(rnd_i[5] && rnd_i[6]);
            drv[5] <= !(rnd_i[5] && rnd_i[7]);
            drv[6] <= !(rnd_i[6] && rnd_i[7]);
            // strobe pulses only in the cycle after a hold
            drv[7] <= !hold || rnd_i[3];
            drv[8] <= hold && rnd_i[4];
        end
        else
        begin
            drv <= 9'h0F3;
            pend <= 2'h0;
        end
    end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "fpu_hold_map.svh"
// ==========
// bench top
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic iu_nullify_i = 1'b0, fetch_strobe_i = 1'b0, fp_instr_i = 1'b0, decode_dep_i = 1'b0;
    logic fp_cond_valid_i = 1'b1, store_start_i = 1'b0, store_double_i = 1'b0, fsr_wr_i = 1'b0;
    logic [63:0] store_word_i = 64'h0;
    logic [31:0] addr_i = 32'h0, data_i = 32'h0;
    logic en = 1'b0, oe_off = 1'b0;
    logic [7:0] rnd = 8'h0;
    logic aux_cop_hold_n_i, aux_cond_valid_i, mem_hold_a_n_i, mem_hold_b_n_i, bus_hold_n_i;
    logic mem_data_strobe_n_i, data_out_en_n_i;
    logic [1:0] aux_cond_bits_i, aux_cond_bits_o;
    logic [31:0] decode_addr_o, buf1_addr_o, data_o, load_data_o, fsr_o;
    logic [3:0] data_oe_o;
    logic fp_own_hold_n_o, freeze_o, nullify_cycle_o, align_err_o;
    logic [3:0] oe_q [0:4];
    logic [31:0] d_q [0:4];
    logic [63:0] w;
    logic err, ok, on, f, p_f, p_s;
    integer seed = 82, failures = 0, cmp_count = 0, k, n;

    always #2.5 clk_sys_i = ~clk_sys_i;

    fpu_hold_and_bus_interface fpu_hold_and_bus_interface_fetch_strobe (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .aux_cop_hold_n_i(aux_cop_hold_n_i),
        .aux_cond_valid_i(aux_cond_valid_i), .aux_cond_bits_i(aux_cond_bits_i),
        .mem_hold_a_n_i(mem_hold_a_n_i), .mem_hold_b_n_i(mem_hold_b_n_i),
        .bus_hold_n_i(bus_hold_n_i), .mem_data_strobe_n_i(mem_data_strobe_n_i),
        .data_out_en_n_i(data_out_en_n_i), .iu_nullify_i(iu_nullify_i),
        .fetch_strobe_i(fetch_strobe_i), .fp_instr_i(fp_instr_i), .decode_dep_i(decode_dep_i),
        .fp_cond_valid_i(fp_cond_valid_i), .store_start_i(store_start_i),
        .store_double_i(store_double_i), .store_word_i(store_word_i), .addr_i(addr_i),
        .data_i(data_i), .fsr_wr_i(fsr_wr_i), .decode_addr_o(decode_addr_o),
        .buf1_addr_o(buf1_addr_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .fp_own_hold_n_o(fp_own_hold_n_o), .freeze_o(freeze_o),
        .nullify_cycle_o(nullify_cycle_o), .align_err_o(align_err_o),
        .load_data_o(load_data_o), .aux_cond_bits_o(aux_cond_bits_o), .fsr_o(fsr_o));
    aux_mem_model aux_mem_model_fetch_strobe (.clk_sys_i(clk_sys_i), .en_i(en), .oe_off_i(oe_off),
        .rnd_i(rnd), .aux_cop_hold_n_o(aux_cop_hold_n_i), .aux_cond_valid_o(aux_cond_valid_i),
        .aux_cond_bits_o(aux_cond_bits_i), .mem_hold_a_n_o(mem_hold_a_n_i),
        .mem_hold_b_n_o(mem_hold_b_n_i), .bus_hold_n_o(bus_hold_n_i),
        .mem_data_strobe_n_o(mem_data_strobe_n_i), .data_out_en_n_o(data_out_en_n_i));

    task chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic aligned(input logic dbl, input logic [31:0] a);
        return dbl ? (a[2:0] == 3'h0) : (a[1:0] == 2'h0);
    endfunction

    // squash and store inputs change only at the falling edge
    task st(input logic dbl, input logic [31:0] a, input logic nul, input logic off);
        addr_i = a;
        store_double_i = dbl;
        iu_nullify_i = nul;
        oe_off = off;
        store_word_i = {$random(seed), $random(seed)};
        w = store_word_i;
        err = 1'b0;
        store_start_i = 1'b1;
        for (k = 0; k < 5; k++)
        begin
            @(negedge clk_sys_i);
            store_start_i = 1'b0;
            oe_q[k] = data_oe_o;
            d_q[k] = data_o;
            err = err | align_err_o;
        end
        ok = !nul && aligned(dbl, a);
        chk(err, !nul && !aligned(dbl, a));
        for (k = 0; k < 5; k++)
        begin
            on = ok && !off && (k == 1 || (k == 2 && dbl));
            chk(oe_q[k], on ? 4'hF : 4'h0);
            if (on)
                chk(d_q[k], (k == 1) ? w[63:32] : w[31:0]);
        end
        iu_nullify_i = 1'b0;
        oe_off = 1'b0;
    endtask

    initial
    begin
        repeat (`RESET_MIN_CYCLES) @(negedge clk_sys_i);
        chk(fsr_o, 32'h0);
        chk(fp_own_hold_n_o, 1'b1);
        rst_i = 1'b0;
        $display("test reset done");
        for (n = 0; n < 3; n++)
        begin
            addr_i = $random(seed);
            fp_instr_i = 1'b1;
            @(negedge clk_sys_i);
            fp_instr_i = 1'b0;
            chk(decode_addr_o, addr_i);
            fetch_strobe_i = 1'b1;
            @(negedge clk_sys_i);
            fetch_strobe_i = 1'b0;
            chk(buf1_addr_o, addr_i);
        end
        $display("test address done");
        st(1'b0, 32'h4, 1'b0, 1'b0);
        st(1'b1, 32'h8, 1'b0, 1'b0);
        st(1'b1, 32'h4, 1'b0, 1'b0);
        st(1'b0, 32'h2, 1'b0, 1'b0);
        st(1'b1, 32'h0, 1'b1, 1'b0);
        st(1'b0, 32'h0, 1'b0, 1'b1);
        $display("test store done");
        fp_instr_i = 1'b1;
        decode_dep_i = 1'b1;
        @(negedge clk_sys_i);
        fp_instr_i = 1'b0;
        decode_dep_i = 1'b0;
        chk(fp_own_hold_n_o, 1'b0);
        f = 1'b0;
        for (n = 0; n < 20 && fp_own_hold_n_o !== 1'b1; n++)
        begin
            f = f | nullify_cycle_o;
            @(negedge clk_sys_i);
        end
        if (n == 20)
        begin
            failures = failures + 1;
            conclude;
        end
        chk(f | nullify_cycle_o, 1'b1);
        $display("test own hold done");
        data_i = 32'hFFFF_FFFF;
        fsr_wr_i = 1'b1;
        @(negedge clk_sys_i);
        fsr_wr_i = 1'b0;
        chk(fsr_o, `FSR_WR_MASK);
        en = 1'b1;
        p_s = 1'b1;
        p_f = 1'b0;
        for (n = 0; n < 400; n++)
        begin
            @(negedge clk_sys_i);
            f = !(aux_cop_hold_n_i && aux_cond_valid_i && mem_hold_a_n_i && mem_hold_b_n_i
                && bus_hold_n_i && fp_cond_valid_i);
            chk(freeze_o, f);
            chk(nullify_cycle_o, !fp_cond_valid_i);
            if (aux_cond_valid_i)
                chk(aux_cond_bits_o, aux_cond_bits_i);
            if (f && p_f && p_s && !mem_data_strobe_n_i)
                chk(load_data_o, data_i);
            p_s = mem_data_strobe_n_i;
            p_f = f;
            rnd <= 8'($random(seed));
            // own inputs frozen while the bus is away
            if (bus_hold_n_i)
            begin
                data_i = $random(seed);
                fp_cond_valid_i = ($random(seed) & 7) != 0;
            end
        end
        en = 1'b0;
        fp_cond_valid_i = 1'b1;
        $display("test random done");
        rst_i = 1'b1;
        repeat (`RESET_MIN_CYCLES) @(negedge clk_sys_i);
        chk(fsr_o, 32'h0);
        rst_i = 1'b0;
        $display("test second reset done");
        conclude;
    end
endmodule
